// >>> common/lmi_pkg.sv
/*
 * shared constants for the literal, move and indirect-store executor:
 * register offsets, command word layout, opcodes, pointer modes, reset values.
 * assumes a 32-bit apb bus with byte addresses and one aligned word per register.
 */
package lmi_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_BANK   = 8'h04;
    localparam logic [7:0] OFS_PAGE   = 8'h08;
    localparam logic [7:0] OFS_ACC    = 8'h0c;
    localparam logic [7:0] OFS_PTR0   = 8'h10;
    localparam logic [7:0] OFS_PTR1   = 8'h14;
    localparam logic [7:0] OFS_OPTION = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_POWER  = 8'h20;
    localparam logic [7:0] OFS_PC     = 8'h24;

    // ------------------------------------------------------------
    // command word layout
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_OP_W     = 4;
    localparam int CMD_ARG_LSB  = 8;
    localparam int CMD_ARG_W    = 8;
    localparam int CMD_MODE_LSB = 16;
    localparam int CMD_SEL_BIT  = 18;
    localparam int CMD_REL_BIT  = 19;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int BANK_W   = 5;
    localparam int PAGE_W   = 7;
    localparam int FILE_W   = 7;
    localparam int OFFS_W   = 6;
    localparam int PTR_W    = 16;
    localparam int PC_W     = 15;
    localparam int STATUS_W = 3;
    localparam logic [7:0] OPTION_RST = 8'hff;
    // file addresses that hold no storage and redirect through a pointer
    localparam logic [FILE_W-1:0] FILE_IND0 = 7'h00;
    localparam logic [FILE_W-1:0] FILE_IND1 = 7'h01;
    localparam logic [PTR_W-1:0]  PTR_ONE   = 16'h0001;

    // ------------------------------------------------------------
    // opcodes and pointer update modes
    // ------------------------------------------------------------
    typedef enum logic [CMD_OP_W-1:0] {
        OP_IDLE     = 4'h0,
        OP_BANK     = 4'h1,
        OP_PAGE     = 4'h2,
        OP_ACC      = 4'h3,
        OP_STORE    = 4'h4,
        OP_INDIRECT = 4'h5,
        OP_OPTION   = 4'h6,
        OP_RESET    = 4'h7
    } opcode_t;

    typedef enum logic [1:0] {
        MODE_PRE_INC  = 2'b00,
        MODE_PRE_DEC  = 2'b01,
        MODE_POST_INC = 2'b10,
        MODE_POST_DEC = 2'b11
    } pointer_update_mode_field_t;
endpackage

// >>> src/lmi_exec.sv
/*
 * literal, move and indirect-store instruction executor with apb registers.
 * assumes an apb master on pclk; instruction words are written to the command
 * register, data memory stores leave through the file write port.
 */
`timescale 1ns/1ps
`default_nettype none
module lmi_exec
    import lmi_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic                          file_wr_en,
    output logic      [lmi_pkg::PTR_W-1:0] file_wr_addr,
    output logic      [7:0]               file_wr_data,
    output logic                          soft_reset
);
    import lmi_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [BANK_W-1:0]   bank_select_register_reg, bank_select_register_next;
    logic [PAGE_W-1:0]   program_counter_high_latch_reg, program_counter_high_latch_next;
    logic [7:0]          acc_reg, acc_next;
    logic [PTR_W-1:0]    file_select_pointer_reg [2];
    logic [PTR_W-1:0]    file_select_pointer_next [2];
    logic [7:0]          option_reg, option_next;
    logic [STATUS_W-1:0] status_reg, status_next;
    logic                reset_instruction_indicator_reg, reset_instruction_indicator_next;
    logic [PC_W-1:0]     pc_reg, pc_next;
    logic [31:0]         prdata_reg, prdata_next;
    logic                pready_reg, pready_next;
    logic                pslverr_reg, pslverr_next;
    logic                wr_en_reg, wr_en_next;
    logic [PTR_W-1:0]    wr_addr_reg, wr_addr_next;
    logic [7:0]          wr_data_reg, wr_data_next;
    logic                soft_reset_reg, soft_reset_next;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic                       access;
    logic                       exec;
    logic [CMD_OP_W-1:0]        cmd_op;
    logic [CMD_ARG_W-1:0]       cmd_arg;
    pointer_update_mode_field_t cmd_mode;
    logic                       cmd_sel;
    logic                       cmd_rel;
    logic [PTR_W-1:0]           sel_ptr;
    logic [PTR_W-1:0]           rel_offset;
    logic [PTR_W-1:0]           ind_addr;
    logic [PTR_W-1:0]           ind_ptr_new;
    logic [FILE_W-1:0]          file_addr;
    logic [PTR_W-1:0]           direct_addr;
    logic                       addr_ok;

    // a write completes at the edge where the access phase sees pready
    assign access   = psel && penable && pready_reg;
    assign exec     = access && pwrite && (paddr == OFS_CMD);
    assign cmd_op   = pwdata[CMD_OP_LSB +: CMD_OP_W];
    assign cmd_arg  = pwdata[CMD_ARG_LSB +: CMD_ARG_W];
    assign cmd_mode = pointer_update_mode_field_t'(pwdata[CMD_MODE_LSB +: 2]);
    assign cmd_sel  = pwdata[CMD_SEL_BIT];
    assign cmd_rel  = pwdata[CMD_REL_BIT];
    assign sel_ptr  = file_select_pointer_reg[cmd_sel];
    // sign-extend the 6-bit offset; plain 16-bit adds give the wrap for free
    assign rel_offset = {{(PTR_W-OFFS_W){cmd_arg[OFFS_W-1]}}, cmd_arg[OFFS_W-1:0]};
    assign file_addr  = cmd_arg[FILE_W-1:0];
    assign direct_addr = {4'h0, bank_select_register_reg, file_addr};

    // effective address and pointer after the move
    always_comb begin
        ind_addr    = sel_ptr;
        ind_ptr_new = sel_ptr;
        if (cmd_rel) begin
            ind_addr = sel_ptr + rel_offset;
        end else begin
            unique case (cmd_mode)
                MODE_PRE_INC: begin
                    ind_addr    = sel_ptr + PTR_ONE;
                    ind_ptr_new = sel_ptr + PTR_ONE;
                end
                MODE_PRE_DEC: begin
                    ind_addr    = sel_ptr - PTR_ONE;
                    ind_ptr_new = sel_ptr - PTR_ONE;
                end
                MODE_POST_INC: begin
                    ind_ptr_new = sel_ptr + PTR_ONE;
                end
                MODE_POST_DEC: begin
                    ind_ptr_new = sel_ptr - PTR_ONE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // core registers
    // ------------------------------------------------------------
    // flags are written by software through the status register; of the instructions only the reset instruction changes them, clearing them
    always_comb begin
        bank_select_register_next        = bank_select_register_reg;
        program_counter_high_latch_next  = program_counter_high_latch_reg;
        acc_next                         = acc_reg;
        file_select_pointer_next         = file_select_pointer_reg;
        option_next                      = option_reg;
        status_next                      = status_reg;
        reset_instruction_indicator_next = reset_instruction_indicator_reg;
        pc_next                          = pc_reg;
        wr_en_next                       = 1'b0;
        wr_addr_next                     = wr_addr_reg;
        wr_data_next                     = wr_data_reg;
        soft_reset_next                  = 1'b0;
        if (access && pwrite) begin
            unique case (paddr)
                OFS_BANK:   bank_select_register_next = pwdata[BANK_W-1:0];
                OFS_PAGE:   program_counter_high_latch_next = pwdata[PAGE_W-1:0];
                OFS_ACC:    acc_next = pwdata[7:0];
                OFS_PTR0:   file_select_pointer_next[0] = pwdata[PTR_W-1:0];
                OFS_PTR1:   file_select_pointer_next[1] = pwdata[PTR_W-1:0];
                OFS_OPTION: option_next = pwdata[7:0];
                OFS_STATUS: status_next = pwdata[STATUS_W-1:0];
                OFS_POWER:  reset_instruction_indicator_next = pwdata[0];
                default: ;
            endcase
        end
        if (exec) begin
            pc_next = pc_reg + 15'h0001;
            unique case (cmd_op)
                OP_BANK: bank_select_register_next = cmd_arg[BANK_W-1:0];
                OP_PAGE: program_counter_high_latch_next = cmd_arg[PAGE_W-1:0];
                OP_ACC:  acc_next = cmd_arg;
                OP_STORE: begin
                    wr_en_next   = 1'b1;
                    wr_data_next = acc_reg;
                    if (file_addr == FILE_IND0)
                        wr_addr_next = file_select_pointer_reg[0];
                    else if (file_addr == FILE_IND1)
                        wr_addr_next = file_select_pointer_reg[1];
                    else
                        wr_addr_next = direct_addr;
                end
                OP_INDIRECT: begin
                    wr_en_next   = 1'b1;
                    wr_addr_next = ind_addr;
                    wr_data_next = acc_reg;
                    file_select_pointer_next[cmd_sel] = ind_ptr_new;
                end
                OP_OPTION: option_next = acc_reg;
                OP_RESET: begin
                    // core registers return to reset values, except the reset indicator, which clears to record the cause
                    bank_select_register_next        = '0;
                    program_counter_high_latch_next  = '0;
                    acc_next                         = '0;
                    file_select_pointer_next[0]      = '0;
                    file_select_pointer_next[1]      = '0;
                    option_next                      = OPTION_RST;
                    status_next                      = '0;
                    pc_next                          = '0;
                    reset_instruction_indicator_next = 1'b0;
                    soft_reset_next                  = 1'b1;
                end
                default: ;                                        // idle and unused codes
            endcase
        end
    end

    // ------------------------------------------------------------
    // apb slave: answers in the first access cycle, data set up at the setup edge
    // ------------------------------------------------------------
    always_comb begin
        addr_ok = 1'b1;
        prdata_next = prdata_reg;
        unique case (paddr)
            OFS_CMD:    prdata_next = 32'h0000_0000;
            OFS_BANK:   prdata_next = {27'h0, bank_select_register_reg};
            OFS_PAGE:   prdata_next = {25'h0, program_counter_high_latch_reg};
            OFS_ACC:    prdata_next = {24'h0, acc_reg};
            OFS_PTR0:   prdata_next = {16'h0, file_select_pointer_reg[0]};
            OFS_PTR1:   prdata_next = {16'h0, file_select_pointer_reg[1]};
            OFS_OPTION: prdata_next = {24'h0, option_reg};
            OFS_STATUS: prdata_next = {29'h0, status_reg};
            OFS_POWER:  prdata_next = {31'h0, reset_instruction_indicator_reg};
            OFS_PC:     prdata_next = {17'h0, pc_reg};
            default: begin
                addr_ok     = 1'b0;
                prdata_next = 32'h0000_0000;
            end
        endcase
        if (!(psel && !penable))
            prdata_next = prdata_reg;
        // pready is high only in the first access cycle, so a transfer takes two edges
        pready_next  = psel && !penable;
        pslverr_next = psel && !penable && !addr_ok;
    end

    // registers only; the pointers share one reset loop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_select_register_reg        <= '0;
            program_counter_high_latch_reg  <= '0;
            acc_reg                         <= '0;
            for (int i = 0; i < 2; i++) file_select_pointer_reg[i] <= '0;
            option_reg                      <= OPTION_RST;
            status_reg                      <= '0;
            reset_instruction_indicator_reg <= 1'b1;
            pc_reg                          <= '0;
            prdata_reg                      <= '0;
            pready_reg                      <= 1'b0;
            pslverr_reg                     <= 1'b0;
            wr_en_reg                       <= 1'b0;
            wr_addr_reg                     <= '0;
            wr_data_reg                     <= '0;
            soft_reset_reg                  <= 1'b0;
        end else begin
            bank_select_register_reg        <= bank_select_register_next;
            program_counter_high_latch_reg  <= program_counter_high_latch_next;
            acc_reg                         <= acc_next;
            file_select_pointer_reg         <= file_select_pointer_next;
            option_reg                      <= option_next;
            status_reg                      <= status_next;
            reset_instruction_indicator_reg <= reset_instruction_indicator_next;
            pc_reg                          <= pc_next;
            prdata_reg                      <= prdata_next;
            pready_reg                      <= pready_next;
            pslverr_reg                     <= pslverr_next;
            wr_en_reg                       <= wr_en_next;
            wr_addr_reg                     <= wr_addr_next;
            wr_data_reg                     <= wr_data_next;
            soft_reset_reg                  <= soft_reset_next;
        end
    end

    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign file_wr_en   = wr_en_reg;
    assign file_wr_addr = wr_addr_reg;
    assign file_wr_data = wr_data_reg;
    assign soft_reset   = soft_reset_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_exec_op(logic [CMD_OP_W-1:0] o);
        exec && (cmd_op == o);
    endsequence
    sequence s_ind(logic r, logic [1:0] m);
        exec && (cmd_op == OP_INDIRECT) && (cmd_rel == r) && (cmd_mode == m);
    endsequence

    a_bank_load: assert property (s_exec_op(OP_BANK) |=>
        bank_select_register_reg == $past(cmd_arg[BANK_W-1:0]))
        else $error("bank select not loaded from operand");
    a_page_load: assert property (s_exec_op(OP_PAGE) |=>
        program_counter_high_latch_reg == $past(cmd_arg[PAGE_W-1:0]))
        else $error("page latch not loaded from operand");
    a_acc_load: assert property (s_exec_op(OP_ACC) |=> acc_reg == $past(cmd_arg))
        else $error("accumulator not loaded from operand");
    a_store_direct: assert property (s_exec_op(OP_STORE) ##0 (file_addr > FILE_IND1) |=>
        file_wr_en && file_wr_data == $past(acc_reg) && file_wr_addr == $past(direct_addr)
        ##1 !file_wr_en)
        else $error("direct store pulse wrong");
    a_store_redirect: assert property (s_exec_op(OP_STORE) ##0 (file_addr == FILE_IND1) |=>
        file_wr_addr == $past(file_select_pointer_reg[1]))
        else $error("indirect port store not redirected");
    a_pre_inc_addr: assert property (s_ind(1'b0, MODE_PRE_INC) |=>
        file_wr_addr == $past(sel_ptr) + PTR_ONE && file_wr_en)
        else $error("pre-increment address wrong");
    a_post_dec_ptr: assert property (s_ind(1'b0, MODE_POST_DEC) ##0 !cmd_sel |=>
        file_select_pointer_reg[0] == $past(file_select_pointer_reg[0]) - PTR_ONE
        && file_wr_addr == $past(file_select_pointer_reg[0]))
        else $error("post-decrement pointer or address wrong");
    // the offset form ignores the mode field, so any mode must leave the pointer alone
    a_offset_keep: assert property (s_exec_op(OP_INDIRECT) ##0 (cmd_rel && cmd_sel) |=>
        file_select_pointer_reg[1] == $past(file_select_pointer_reg[1])
        && file_wr_addr == $past(file_select_pointer_reg[1] + rel_offset))
        else $error("offset form moved the pointer");
    a_ptr_wrap: assert property (s_ind(1'b0, MODE_POST_INC) ##0 (!cmd_sel
        && file_select_pointer_reg[0] == 16'hffff) |=> file_select_pointer_reg[0] == 16'h0000)
        else $error("pointer did not wrap");
    a_flags_hold: assert property (exec && cmd_op != OP_RESET |=> $stable(status_reg))
        else $error("status flags changed by instruction");
    a_option_load: assert property (s_exec_op(OP_OPTION) |=> option_reg == $past(acc_reg))
        else $error("option register not loaded");
    a_soft_reset: assert property (s_exec_op(OP_RESET) |=>
        soft_reset && !reset_instruction_indicator_reg && acc_reg == 8'h00 ##1 !soft_reset)
        else $error("software reset effects missing");
    a_idle_only_pc: assert property (s_exec_op(OP_IDLE) |=>
        pc_reg == $past(pc_reg) + 15'h0001 && $stable(acc_reg) && !file_wr_en
        && $stable(bank_select_register_reg) && $stable(option_reg))
        else $error("idle instruction changed state");
endmodule
`default_nettype wire

// >>> verif/file_mem_model.sv
/*
 * data memory model on the file store port: keeps every stored byte.
 * assumes store strobes last one pclk cycle each.
 */
`timescale 1ns/1ps
`default_nettype none
module file_mem_model
    import lmi_pkg::*;
(
    input wire logic                      pclk,
    input wire logic                      file_wr_en,
    input wire logic [lmi_pkg::PTR_W-1:0] file_wr_addr,
    input wire logic [7:0]                file_wr_data
);
    logic [7:0] mem [int];
    int         stores = 0;
    // a strobe held too long counts twice here, so the bench sees it
    always @(posedge pclk) begin
        if (file_wr_en === 1'b1) begin
            mem[int'(file_wr_addr)] = file_wr_data;
            stores++;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_literal_move_indirect_exec.sv
/*
 * self-checking bench for the executor: integer model vs design registers.
 * assumes zero-wait apb answers and registered store strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_literal_move_indirect_exec;
    import lmi_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    wire logic [31:0] prdata;
    wire logic        pready, pslverr, file_wr_en, soft_reset;
    wire logic [15:0] file_wr_addr;
    wire logic [7:0]  file_wr_data;
    int fails = 0, tests_run = 0, stores = 0;
    int acc = 0, bank = 0, page = 0, opt = 255, st = 0, pw = 1, pc = 0;
    int ptr [2] = '{0, 0};
    always #20 pclk = ~pclk;
    lmi_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
        .file_wr_data(file_wr_data), .soft_reset(soft_reset));
    file_mem_model u_mem (.pclk(pclk), .file_wr_en(file_wr_en),
        .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task final_report;
        $display("counts: %0d compares, %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; the wait is bounded so a dead slave ends the run
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin fails++; final_report(); end
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // read back every register except the command register against the model
    task sweep;
        int e [10];
        e = '{0, bank, page, acc, ptr[0], ptr[1], opt, st, pw, pc};
        for (int i = 1; i < 10; i++) begin
            apb(0, 8'(i * 4), 0);
            check(rd, e[i], "register readback");
        end
    endtask
    // run one command on model and design, then compare strobes and state
    task cmd(input int op, input int arg, input int mode, input int sel, input int rel);
        int f, d, wa, we, wd;
        we = 0; wa = 0; wd = acc; f = arg & 127;
        d = (mode & 1) ? -1 : 1;
        case (op)
            1: bank = arg & 31;
            2: page = arg & 127;
            3: acc = arg & 255;
            4: begin we = 1; wa = f == 0 ? ptr[0] : f == 1 ? ptr[1] : (bank << 7) | f; end
            5: begin
                we = 1;
                if (rel) wa = (ptr[sel] + ((arg & 32) ? (arg & 63) - 64 : arg & 63)) & 16'hffff;
                else begin
                    wa = (mode & 2) ? ptr[sel] : (ptr[sel] + d) & 16'hffff;
                    ptr[sel] = (ptr[sel] + d) & 16'hffff;
                end
            end
            6: opt = acc;
            7: begin acc = 0; bank = 0; page = 0; ptr = '{0, 0}; st = 0; opt = 255; pw = 0; end
            default: ;
        endcase
        pc = (op == 7) ? 0 : (pc + 1) & 16'h7fff;
        stores += we;
        apb(1, OFS_CMD, (rel << 19) | (sel << 18) | (mode << 16) | ((arg & 255) << 8) | op);
        @(posedge pclk);
        check(file_wr_en, we, "store strobe");
        check(soft_reset, op == 7, "soft reset strobe");
        if (we) check({file_wr_data, file_wr_addr}, (wd << 16) | wa, "store address/data");
        sweep();
        // the partner has latched the byte by now; its copy must match the model
        if (we) check(u_mem.mem[wa], wd, "partner memory byte");
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h67b455b9));
        repeat (3) @(posedge pclk);
        presetn <= 1;
        sweep();
        $display("test reset values done");
        apb(1, OFS_STATUS, 7); st = 7;
        cmd(1, 31, 0, 0, 0); cmd(2, 127, 0, 0, 0); cmd(3, 255, 0, 0, 0);
        repeat (3) begin
            cmd(1, $urandom % 32, 0, 0, 0); cmd(2, $urandom % 128, 0, 0, 0);
            cmd(3, $urandom % 256, 0, 0, 0);
        end
        $display("test literal loads done");
        apb(1, OFS_PTR0, 32'h1234); ptr[0] = 'h1234;
        apb(1, OFS_PTR1, 32'hbeef); ptr[1] = 'hbeef;
        cmd(4, 2 + $urandom % 126, 0, 0, 0); cmd(4, 0, 0, 0, 0); cmd(4, 1, 0, 0, 0);
        $display("test file stores done");
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 4; m++) begin
                ptr[s] = (m & 1) ? 0 : 'hffff;
                apb(1, s ? OFS_PTR1 : OFS_PTR0, ptr[s]);
                cmd(5, $urandom % 256, m, s, 0);
            end
        end
        apb(1, OFS_PTR0, 32'h0010); ptr[0] = 'h10;
        cmd(5, 32, 0, 0, 1); cmd(5, 31, 3, 1, 1);
        $display("test indirect stores done");
        cmd(3, 8'h4f, 0, 0, 0); cmd(6, 0, 0, 0, 0);
        cmd(0, 0, 0, 0, 0); cmd(9, 200, 3, 1, 1);
        $display("test option and idle done");
        apb(1, 8'h40, 32'h5a); check(err, 1, "unmapped write error");
        apb(0, 8'h40, 0); check(err, 1, "unmapped read error");
        check(rd, 0, "unmapped read data");
        // program counter is read only and the command register reads as zero
        apb(1, OFS_PC, 32'h5); apb(0, OFS_PC, 0); check(rd, pc, "pc write ignored");
        apb(0, OFS_CMD, 0); check(rd, 0, "command register reads zero");
        cmd(7, 0, 0, 0, 0);
        check(u_mem.stores, stores, "partner store count");
        $display("test reset command done");
        final_report();
    end
endmodule
`default_nettype wire
